// ===== cvo_pkg.sv
// Purpose: Shared constants, timing and CRC helper for the value-operation link
// Assumes: 40 MHz clk on both ends; bytes go least significant bit first
// Notes:   Frame CRC is the Type A CRC, reflected, preset 6363h
package cvo_pkg;
  // ****************************************
  // Opcodes and reply codes
  // ****************************************
  localparam logic [7:0] OP_DEC   = 8'hC0;  // Decrement
  localparam logic [7:0] OP_INC   = 8'hC1;  // Increment
  localparam logic [7:0] OP_RES   = 8'hC2;  // Restore
  localparam logic [7:0] OP_XFER  = 8'hB0;  // Transfer
  localparam logic [3:0] RSP_ACK  = 4'hA;   // Acknowledge
  localparam logic [3:0] RSP_NPRM = 4'h4;   // Refused: block, op or session
  localparam logic [3:0] RSP_NCRC = 4'h5;   // Refused: bad CRC
  localparam logic [3:0] RSP_NONE = 4'h0;   // Nothing heard
  localparam int         RSP_BITS = 4;      // Reply length in bits
  // ****************************************
  // Frame layout
  // ****************************************
  localparam int          CMD_LEN  = 4;     // Opcode, address, CRC
  localparam int          OPD_LEN  = 6;     // Operand word, CRC
  localparam int          MAX_LEN  = 6;     // Longest frame
  localparam logic [15:0] CRC_INIT = 16'h6363;
  localparam logic [15:0] CRC_POLY = 16'h8408;
  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_PERIOD_PS = 25000;   // 40 MHz
  localparam int ACK_MIN_NS    = 71000;   // Least reply delay
  localparam int GAP_MIN_NS    = 87000;   // Least frame delay, reader side
  localparam int TOUT_VAL_US   = 5000;    // Value op timeout
  localparam int TOUT_XFER_US  = 10000;   // Transfer timeout
  localparam int ACK_MIN_CYC   = (ACK_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int GAP_MIN_CYC   = (GAP_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int TOUT_VAL_CYC  = TOUT_VAL_US * 1000 / (CLK_PERIOD_PS / 1000);
  localparam int TOUT_XFER_CYC = TOUT_XFER_US * 1000 / (CLK_PERIOD_PS / 1000);
  localparam int LINK_DIV      = 8;       // 200 ns link bit clock

  // One byte through the frame CRC
  function automatic logic [15:0] cvoCrcByte(logic [15:0] crc, logic [7:0] b);
    logic [15:0] c;
    c = crc;
    for (int i = 0; i < 8; i++) begin
      c = (c[0] ^ b[i]) ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
    end
    return c;
  endfunction : cvoCrcByte

  // Opcodes that take a second, operand frame
  function automatic logic cvoIsValOp(logic [7:0] op);
    return (op == OP_INC) || (op == OP_DEC) || (op == OP_RES);
  endfunction : cvoIsValOp
endpackage : cvo_pkg

// ===== cvo_link_if.sv
// Purpose: Link between reader end and card end
// Assumes: Reader makes lnkClk; each end samples the other's pins
// Notes:   Pure wires, no clocking block
`timescale 1ns/1ps
interface cvo_link_if;
  logic lnkClk;   // Bit clock from the reader
  logic rdrFrm;   // Reader frame active
  logic rdrDat;   // Reader data bit
  logic cardFrm;  // Card reply active
  logic cardDat;  // Card reply bit
  modport reader (output lnkClk, output rdrFrm, output rdrDat, input cardFrm, input cardDat);
  modport card   (input lnkClk, input rdrFrm, input rdrDat, output cardFrm, output cardDat);
endinterface : cvo_link_if

// ===== cvo_card.sv
// Purpose: Card end: value operations into a volatile register, transfer to store
// Assumes: Block store answers nvRdData and nvPermit combinationally, in the same cycle as nvAddr/nvOp
// Notes:   Link pins are sampled through two flops before use
// What this block does
// RL1 - Increment adds operand to source block value
// RL2 - Decrement subtracts operand from source block value
// RL3 - Restore copies source block value unchanged
// RL4 - Reader sends opcode then one-byte address
// RL5 - Operand is a four-byte signed integer
// RL6 - Every frame carries CRC, checked before acting
// RL7 - No reply to part 2; reader waits timeout
// RL8 - Part 1 reply no earlier than 71 us
// RL9 - Card never times out between parts
// RL10 - Results stay volatile until a transfer
// RL11 - Transfer writes volatile value to destination
// RL12 - Transfer frame: opcode, address, CRC only
// RL13 - Transfer reply after 71 us; 10 ms allowed
// RL14 - Delays count from end of reader frame
// RL15 - Ah acknowledges, any other code refuses
// RL16 - Value commands need an authenticated session
// RL17 - Refused part 1 leaves value register unchanged
`timescale 1ns/1ps
module cvo_card
  import cvo_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        nrst,
  cvo_link_if.card         lnk,
  input  wire logic        authOk,     // Session established
  output logic [7:0]       nvAddr,     // Addressed block
  output logic [7:0]       nvOp,       // Operation asked of that block
  input  wire logic [31:0] nvRdData,   // Value held in the block
  input  wire logic        nvPermit,   // Block allows nvOp
  output logic             nvWrEn,     // One-cycle write request
  output logic [31:0]      nvWrData,   // Value to commit
  input  wire logic        nvWrDone,   // Write finished pulse
  output logic [31:0]      valueReg    // Volatile value register
);
  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [2:0] sync1_q;   // First stage: clock, frame, data
  logic [2:0] sync2_q;   // Second stage
  logic       clkOld_q;  // Previous synced link clock
  logic       frmOld_q;  // Previous synced frame

  // Two flops, then edge history
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sync1_q  <= 3'h0;
      sync2_q  <= 3'h0;
      clkOld_q <= 1'b0;
      frmOld_q <= 1'b0;
    end else begin
      sync1_q  <= {lnk.lnkClk, lnk.rdrFrm, lnk.rdrDat};
      sync2_q  <= sync1_q;
      clkOld_q <= sync2_q[2];
      frmOld_q <= sync2_q[1];
    end
  end

  logic linkRise;   // Link clock rising, one cycle
  logic frmEnd;     // Reader frame just closed
  assign linkRise = sync2_q[2] & ~clkOld_q;
  assign frmEnd   = frmOld_q & ~sync2_q[1];   // see RL14

  // ****************************************
  // Frame receiver
  // ****************************************
  logic [7:0]  rxBuf_q [MAX_LEN];  // Received bytes
  logic [7:0]  rxBuf_d [MAX_LEN];
  logic [7:0]  shift_q, shift_d;   // Byte in assembly
  logic [2:0]  bitCnt_q, bitCnt_d; // Bits of current byte
  logic [3:0]  len_q, len_d;       // Whole bytes received
  logic [15:0] crc_q, crc_d;       // Running CRC

  // Shift bits in on link rise while framed
  always_comb begin
    rxBuf_d  = rxBuf_q;
    shift_d  = shift_q;
    bitCnt_d = bitCnt_q;
    len_d    = len_q;
    crc_d    = crc_q;
    if (frmEnd) begin
      // Fresh frame state once the frame is consumed
      bitCnt_d = 3'h0;
      len_d    = 4'h0;
      crc_d    = CRC_INIT;
    end else if (linkRise && sync2_q[1]) begin
      shift_d  = {sync2_q[0], shift_q[7:1]};
      bitCnt_d = bitCnt_q + 3'h1;
      if (bitCnt_q == 3'h7) begin
        // Overlong frames keep counting so length checks fail
        if (len_q < 4'(MAX_LEN)) begin
          rxBuf_d[len_q[2:0]] = shift_d;
        end
        if (len_q != 4'hF) begin
          len_d = len_q + 4'h1;
        end
        crc_d = cvoCrcByte(crc_q, shift_d);  // see RL6
      end
    end
  end

  // Receiver registers
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < MAX_LEN; i++) begin
        rxBuf_q[i] <= 8'h00;
      end
      shift_q  <= 8'h00;
      bitCnt_q <= 3'h0;
      len_q    <= 4'h0;
      crc_q    <= CRC_INIT;
    end else begin
      rxBuf_q  <= rxBuf_d;
      shift_q  <= shift_d;
      bitCnt_q <= bitCnt_d;
      len_q    <= len_d;
      crc_q    <= crc_d;
    end
  end

  // Residue is zero when data plus CRC agree
  logic crcOk;      // Frame CRC good, whole bytes
  logic [31:0] opnd;  // Operand, low byte first
  assign crcOk = (crc_q == 16'h0000) && (bitCnt_q == 3'h0);  // see RL6
  assign opnd  = {rxBuf_q[3], rxBuf_q[2], rxBuf_q[1], rxBuf_q[0]};  // see RL5

  // ****************************************
  // Command control
  // ****************************************
  typedef enum logic [4:0] {
    C_IDLE  = 5'b00001,  // Waiting for a frame
    C_FETCH = 5'b00010,  // Store answering address
    C_WRITE = 5'b00100,  // Committing value
    C_DELAY = 5'b01000,  // Holding off the reply
    C_TX    = 5'b10000   // Sending four-bit reply
  } cvo_card_st_t;

  cvo_card_st_t st_q, st_d;         // Controller state
  logic        await_q, await_d;    // Part 2 expected
  logic [7:0]  op_q, op_d;          // Latched opcode
  logic [7:0]  addr_q, addr_d;      // Latched block address
  logic [31:0] src_q, src_d;        // Source block value
  logic [31:0] val_q, val_d;        // Volatile value register
  logic [11:0] dly_q, dly_d;        // Cycles since frame end
  logic [3:0]  code_q, code_d;      // Reply code
  logic [2:0]  txCnt_q, txCnt_d;    // Reply bits sent
  logic        cFrm_q, cFrm_d;      // Reply frame pin
  logic        cDat_q, cDat_d;      // Reply data pin
  logic        wrEn_q, wrEn_d;      // Store write pulse

  // Next-state logic of the controller
  always_comb begin
    st_d    = st_q;
    await_d = await_q;
    op_d    = op_q;
    addr_d  = addr_q;
    src_d   = src_q;
    val_d   = val_q;
    code_d  = code_q;
    txCnt_d = txCnt_q;
    cFrm_d  = cFrm_q;
    cDat_d  = cDat_q;
    wrEn_d  = 1'b0;
    // Free count from frame end, saturating; no wait between parts ends
    dly_d   = (dly_q == 12'hFFF) ? dly_q : dly_q + 12'h1;  // see RL9
    if (frmEnd) begin
      dly_d = 12'h0;  // see RL14
    end
    unique case (st_q)
      C_IDLE: begin
        if (frmEnd) begin
          if (await_q) begin
            // Part 2: commit to volatile register only, stay silent
            await_d = 1'b0;  // see RL7
            if ((len_q == 4'(OPD_LEN)) && crcOk) begin
              if (op_q == OP_INC) begin
                val_d = $signed(src_q) + $signed(opnd);  // see RL1 see RL5 see RL10
              end else if (op_q == OP_DEC) begin
                val_d = $signed(src_q) - $signed(opnd);  // see RL2 see RL10
              end else begin
                val_d = src_q;  // see RL3
              end
            end
          end else if ((len_q == 4'(CMD_LEN)) &&
                       (cvoIsValOp(rxBuf_q[0]) || (rxBuf_q[0] == OP_XFER))) begin
            if (!crcOk) begin
              code_d = RSP_NCRC;  // see RL17
              st_d   = C_DELAY;
            end else if (!authOk) begin
              code_d = RSP_NPRM;  // see RL16
              st_d   = C_DELAY;
            end else begin
              op_d   = rxBuf_q[0];  // see RL4 see RL12
              addr_d = rxBuf_q[1];
              st_d   = C_FETCH;
            end
          end
          // Other frames belong to other commands
        end
      end
      C_FETCH: begin
        if (!nvPermit) begin
          code_d = RSP_NPRM;  // see RL17
          st_d   = C_DELAY;
        end else if (op_q == OP_XFER) begin
          wrEn_d = 1'b1;  // see RL11
          st_d   = C_WRITE;
        end else begin
          src_d   = nvRdData;
          code_d  = RSP_ACK;
          await_d = 1'b1;
          st_d    = C_DELAY;
        end
      end
      C_WRITE: begin
        // Reply only once the store has the value
        if (nvWrDone) begin
          code_d = RSP_ACK;  // see RL13
          st_d   = C_DELAY;
        end
      end
      C_DELAY: begin
        if (dly_q >= 12'(ACK_MIN_CYC)) begin
          txCnt_d = 3'h0;  // see RL8 see RL13
          st_d    = C_TX;
        end
      end
      C_TX: begin
        // Bits change just after a link rise, low bit first
        if (linkRise) begin
          if (txCnt_q == 3'(RSP_BITS)) begin
            cFrm_d = 1'b0;
            cDat_d = 1'b0;
            st_d   = C_IDLE;
          end else begin
            cFrm_d  = 1'b1;
            cDat_d  = code_q[txCnt_q[1:0]];  // see RL15
            txCnt_d = txCnt_q + 3'h1;
          end
        end
      end
    endcase
  end

  // Controller registers
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_q    <= C_IDLE;
      await_q <= 1'b0;
      op_q    <= 8'h00;
      addr_q  <= 8'h00;
      src_q   <= 32'h0000_0000;
      val_q   <= 32'h0000_0000;
      dly_q   <= 12'h000;
      code_q  <= RSP_NONE;
      txCnt_q <= 3'h0;
      cFrm_q  <= 1'b0;
      cDat_q  <= 1'b0;
      wrEn_q  <= 1'b0;
    end else begin
      st_q    <= st_d;
      await_q <= await_d;
      op_q    <= op_d;
      addr_q  <= addr_d;
      src_q   <= src_d;
      val_q   <= val_d;
      dly_q   <= dly_d;
      code_q  <= code_d;
      txCnt_q <= txCnt_d;
      cFrm_q  <= cFrm_d;
      cDat_q  <= cDat_d;
      wrEn_q  <= wrEn_d;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign lnk.cardFrm = cFrm_q;
  assign lnk.cardDat = cDat_q;
  assign nvAddr      = addr_q;
  assign nvOp        = op_q;
  assign nvWrEn      = wrEn_q;
  assign nvWrData    = val_q;   // see RL11
  assign valueReg    = val_q;
endmodule : cvo_card

// ===== cvo_reader.sv
// Purpose: Reader end: sends value commands and transfer, collects replies
// Assumes: One command in flight; user holds cmd fields until rspValid, cmdOperand is read for part 2
// Notes:   Link clock is divided from clk and always runs
`timescale 1ns/1ps
module cvo_reader
  import cvo_pkg::*;
#(
  parameter int TOUT_VAL  = TOUT_VAL_CYC,   // Value op timeout, cycles
  parameter int TOUT_XFER = TOUT_XFER_CYC   // Transfer timeout, cycles
)(
  input  wire logic        clk,
  input  wire logic        nrst,
  cvo_link_if.reader       lnk,
  input  wire logic        cmdValid,    // Command offered
  output logic             cmdReady,    // Idle, command taken
  input  wire logic [7:0]  cmdOp,       // Opcode
  input  wire logic [7:0]  cmdAddr,     // Block address
  input  wire logic [31:0] cmdOperand,  // Signed operand
  output logic             rspValid,    // Command finished pulse
  output logic [3:0]       rspCode,     // Part 1 reply code
  output logic             rspTimeout   // No reply heard
);
  localparam int TW = $clog2(TOUT_XFER + 1);  // Timer width

  // ****************************************
  // Link clock divider and reply sync
  // ****************************************
  logic [2:0] div_q;     // Divider phase
  logic [1:0] sync1_q;   // Reply pins, first stage
  logic [1:0] sync2_q;   // Reply pins, second stage

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      div_q   <= 3'h0;
      sync1_q <= 2'h0;
      sync2_q <= 2'h0;
    end else begin
      div_q   <= (div_q == 3'(LINK_DIV - 1)) ? 3'h0 : div_q + 3'h1;
      sync1_q <= {lnk.cardFrm, lnk.cardDat};
      sync2_q <= sync1_q;
    end
  end

  logic riseTick;  // Link clock about to rise
  logic fallTick;  // Link clock about to fall
  assign riseTick   = (div_q == 3'(LINK_DIV - 1));
  assign fallTick   = (div_q == 3'(LINK_DIV / 2 - 1));
  assign lnk.lnkClk = (div_q < 3'(LINK_DIV / 2));

  // ****************************************
  // Sequencer
  // ****************************************
  typedef enum logic [4:0] {
    R_IDLE   = 5'b00001,  // Ready for a command
    R_TX     = 5'b00010,  // Sending a frame
    R_WAIT   = 5'b00100,  // Waiting for a reply
    R_GAP    = 5'b01000,  // Frame delay before part 2
    R_SILENT = 5'b10000   // Part 2 sent, no reply due
  } cvo_rdr_st_t;

  cvo_rdr_st_t st_q, st_d;            // Sequencer state
  logic [7:0]  buf_q [MAX_LEN];       // Frame bytes
  logic [7:0]  buf_d [MAX_LEN];
  logic [3:0]  len_q, len_d;          // Frame length
  logic [3:0]  byte_q, byte_d;        // Byte being sent
  logic [2:0]  bit_q, bit_d;          // Bit being sent
  logic        part2_q, part2_d;      // Sending operand frame
  logic [TW-1:0] tmr_q, tmr_d;        // Cycles since frame end
  logic [3:0]  rx_q, rx_d;            // Reply bits
  logic [2:0]  rxCnt_q, rxCnt_d;      // Reply bit count
  logic        frm_q, frm_d;          // Frame pin
  logic        dat_q, dat_d;          // Data pin
  logic        vld_q, vld_d;          // Done pulse
  logic [3:0]  code_q, code_d;        // Result code
  logic        tout_q, tout_d;        // Result timeout flag
  logic [TW-1:0] limit;               // Timeout for this opcode
  logic [15:0] crc;                   // Scratch CRC

  assign limit = (buf_q[0] == OP_XFER && !part2_q) ? TW'(TOUT_XFER) : TW'(TOUT_VAL);  // see RL13

  always_comb begin
    crc     = CRC_INIT;
    st_d    = st_q;
    buf_d   = buf_q;
    len_d   = len_q;
    byte_d  = byte_q;
    bit_d   = bit_q;
    part2_d = part2_q;
    tmr_d   = tmr_q + TW'(1);
    rx_d    = rx_q;
    rxCnt_d = rxCnt_q;
    frm_d   = frm_q;
    dat_d   = dat_q;
    vld_d   = 1'b0;
    code_d  = code_q;
    tout_d  = tout_q;
    unique case (st_q)
      R_IDLE: begin
        if (cmdValid) begin
          // Opcode, address, CRC low then high
          buf_d[0] = cmdOp;  // see RL4 see RL12
          buf_d[1] = cmdAddr;
          crc      = cvoCrcByte(cvoCrcByte(CRC_INIT, cmdOp), cmdAddr);
          buf_d[2] = crc[7:0];  // see RL6
          buf_d[3] = crc[15:8];
          len_d    = 4'(CMD_LEN);
          part2_d  = 1'b0;
          byte_d   = 4'h0;
          bit_d    = 3'h0;
          st_d     = R_TX;
        end
      end
      R_TX: begin
        if (fallTick) begin
          if (byte_q == len_q) begin
            frm_d   = 1'b0;
            dat_d   = 1'b0;
            tmr_d   = '0;  // see RL14
            rxCnt_d = 3'h0;
            st_d    = part2_q ? R_SILENT : R_WAIT;
          end else begin
            frm_d = 1'b1;
            dat_d = buf_q[byte_q[2:0]][bit_q];
            bit_d = bit_q + 3'h1;
            if (bit_q == 3'h7) begin
              byte_d = byte_q + 4'h1;
            end
          end
        end
      end
      R_WAIT: begin
        if (riseTick && sync2_q[1] && rxCnt_q != 3'(RSP_BITS)) begin
          rx_d[rxCnt_q[1:0]] = sync2_q[0];
          rxCnt_d = rxCnt_q + 3'h1;
        end else if (rxCnt_q == 3'(RSP_BITS)) begin
          code_d = rx_q;  // see RL15
          tout_d = 1'b0;
          if (rx_q == RSP_ACK && cvoIsValOp(buf_q[0])) begin
            tmr_d = '0;
            st_d  = R_GAP;
          end else begin
            vld_d = 1'b1;
            st_d  = R_IDLE;
          end
        end else if (tmr_q >= limit) begin
          code_d = RSP_NONE;  // see RL8 see RL13
          tout_d = 1'b1;
          vld_d  = 1'b1;
          st_d   = R_IDLE;
        end
      end
      R_GAP: begin
        if (tmr_q >= TW'(GAP_MIN_CYC)) begin
          // Operand low byte first, then CRC
          for (int i = 0; i < 4; i++) begin
            buf_d[i] = cmdOperand[8*i +: 8];  // see RL5 see RL9
            crc      = cvoCrcByte(crc, cmdOperand[8*i +: 8]);
          end
          buf_d[4] = crc[7:0];  // see RL6
          buf_d[5] = crc[15:8];
          len_d    = 4'(OPD_LEN);
          part2_d  = 1'b1;
          byte_d   = 4'h0;
          bit_d    = 3'h0;
          st_d     = R_TX;
        end
      end
      R_SILENT: begin
        // Card stays quiet; only the full timeout ends the command
        if (tmr_q >= TW'(TOUT_VAL)) begin
          vld_d = 1'b1;  // see RL7 see RL10
          st_d  = R_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_q    <= R_IDLE;
      for (int i = 0; i < MAX_LEN; i++) begin
        buf_q[i] <= 8'h00;
      end
      len_q   <= 4'h0;
      byte_q  <= 4'h0;
      bit_q   <= 3'h0;
      part2_q <= 1'b0;
      tmr_q   <= '0;
      rx_q    <= 4'h0;
      rxCnt_q <= 3'h0;
      frm_q   <= 1'b0;
      dat_q   <= 1'b0;
      vld_q   <= 1'b0;
      code_q  <= RSP_NONE;
      tout_q  <= 1'b0;
    end else begin
      st_q    <= st_d;
      buf_q   <= buf_d;
      len_q   <= len_d;
      byte_q  <= byte_d;
      bit_q   <= bit_d;
      part2_q <= part2_d;
      tmr_q   <= tmr_d;
      rx_q    <= rx_d;
      rxCnt_q <= rxCnt_d;
      frm_q   <= frm_d;
      dat_q   <= dat_d;
      vld_q   <= vld_d;
      code_q  <= code_d;
      tout_q  <= tout_d;
    end
  end

  assign cmdReady   = (st_q == R_IDLE);
  assign lnk.rdrFrm = frm_q;
  assign lnk.rdrDat = dat_q;
  assign rspValid   = vld_q;
  assign rspCode    = code_q;
  assign rspTimeout = tout_q;
endmodule : cvo_reader

// ===== cvo_link_sva.sv
// Purpose: Protocol checker on the wires between reader end and card end
// Assumes: One clk domain; both ends are design modules
// Notes:   Frame and reply lengths are counted in link bits and clk cycles
`timescale 1ns/1ps
module cvo_link_sva
  import cvo_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic lnkClk,
  input wire logic rdrFrm,
  input wire logic rdrDat,
  input wire logic cardFrm,
  input wire logic cardDat
);
  localparam int RSP_LO = 2840;  // Least reply delay in cycles
  localparam int RSP_HI = 3000;  // Slack for sync flops and bit alignment
  logic        lnkPrev_q, lnkPrev_d;    // Link clock, last cycle
  logic        frmPrev_q, frmPrev_d;    // Reader frame, last cycle
  logic [5:0]  bitCnt_q, bitCnt_d;      // Bits of the current frame
  logic [5:0]  lastLen_q, lastLen_d;    // Bits of the last frame
  logic [5:0]  rplLen_q, rplLen_d;      // Cycles of the current reply
  logic [11:0] sinceEnd_q, sinceEnd_d;  // Cycles since frame end, saturating
  logic        cardPrev_q, cardPrev_d;  // Card reply, last cycle
  logic [11:0] waitCnt_q, waitCnt_d;    // Cycles awaiting a reply
  // ****************************************
  // Helper counters
  // ****************************************
  always_comb begin
    lnkPrev_d  = lnkClk;
    frmPrev_d  = rdrFrm;
    bitCnt_d   = rdrFrm ? bitCnt_q + 6'(lnkClk & ~lnkPrev_q) : 6'h0;
    lastLen_d  = (frmPrev_q && !rdrFrm) ? bitCnt_q : lastLen_q;
    rplLen_d   = cardFrm ? rplLen_q + 6'h1 : 6'h0;
    // Saturate so a long idle never wraps into a false short delay
    sinceEnd_d = (frmPrev_q && !rdrFrm) ? 12'h1 : sinceEnd_q + 12'(sinceEnd_q != 12'hFFF);
    cardPrev_d = cardFrm;
    waitCnt_d  = (frmPrev_q && !rdrFrm && bitCnt_q == 6'h20) ? 12'h1 :
                 (cardFrm && !cardPrev_q) ? 12'h0 : waitCnt_q + 12'(waitCnt_q != 12'h0);
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      {lnkPrev_q, frmPrev_q, bitCnt_q, lastLen_q, rplLen_q, sinceEnd_q, cardPrev_q, waitCnt_q} <= '0;
    end else begin
      {lnkPrev_q, frmPrev_q, bitCnt_q} <= {lnkPrev_d, frmPrev_d, bitCnt_d};
      {lastLen_q, rplLen_q, sinceEnd_q} <= {lastLen_d, rplLen_d, sinceEnd_d};
      {cardPrev_q, waitCnt_q} <= {cardPrev_d, waitCnt_d};
    end
  end
  // ****************************************
  // Link assertions
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  a_reply_min_dly: assert property ($rose(cardFrm) |-> sinceEnd_q >= 12'(ACK_MIN_CYC))
    else $error("card reply came too early");
  a_reply_window: assert property ($rose(cardFrm) |-> waitCnt_q >= 12'(RSP_LO))
    else $error("card reply outside its window");
  a_reply_due: assert property (waitCnt_q <= 12'(RSP_HI))
    else $error("no card reply to a command frame");
  a_reply_len: assert property ($fell(cardFrm) |-> rplLen_q == 6'h20)
    else $error("card reply not four bits long");
  a_reply_cmd_only: assert property ($rose(cardFrm) |-> lastLen_q == 6'h20)
    else $error("card replied to an operand frame");
  a_frame_len: assert property ($fell(rdrFrm) |-> bitCnt_q inside {6'h20, 6'h30})
    else $error("reader frame of wrong length");
  a_dat_held: assert property ((rdrFrm && lnkClk && $past(lnkClk)) |-> $stable(rdrDat))
    else $error("reader data moved while link clock high");
  a_frm_start: assert property ($rose(rdrFrm) |-> !lnkClk)
    else $error("reader frame began with link clock high");
  a_clk_shape: assert property ($rose(lnkClk) |-> lnkClk[*4] ##1 (!lnkClk)[*4] ##1 lnkClk)
    else $error("link clock not four high four low");
endmodule : cvo_link_sva

// ===== card_value_op_handler_tb.sv
// Purpose: Runs value operations and transfers end to end across the link
// Assumes: Store answers combinationally; write done one cycle after request
// Notes:   Reader timeouts shortened so each value op stays short
`timescale 1ns/1ps
module card_value_op_handler_tb;
  import cvo_pkg::*;
  typedef struct {logic [3:0] code; logic [31:0] val; logic [7:0] ma; logic [31:0] mv;} cvo_note_t;
  localparam logic [7:0] OPS [7] = '{OP_RES, OP_XFER, OP_INC, OP_DEC, OP_XFER, OP_INC, OP_DEC};
  localparam logic [7:0] ADRS [7] = '{8'h05, 8'hFF, 8'h10, 8'h20, 8'h00, 8'h33, 8'h10};
  localparam logic       AUTH [7] = '{1'h1, 1'h1, 1'h1, 1'h1, 1'h1, 1'h1, 1'h0};
  logic clk = 1'h0, nrst = 1'h0, authOk = 1'h0, cmdValid = 1'h0, nvWrDone = 1'h0;
  logic [7:0]  cmdOp = 8'h0, cmdAddr = 8'h0, nvAddr, nvOp;
  logic [31:0] cmdOperand = 32'h0, nvRdData, nvWrData, valueReg, expV = 32'h0;
  logic [31:0] mem [256];           // Block store model
  logic [255:0] permit = '1;        // Blocks open to value ops
  logic cmdReady, rspValid, rspTimeout, nvWrEn;
  logic [3:0] rspCode;
  int miscompares = 0, testsRun = 0, cyc = 0;
  cvo_note_t notes [$];             // Expected results, oldest first
  cvo_link_if lnk();
  cvo_reader #(.TOUT_VAL(4000), .TOUT_XFER(8000)) cvo_reader_i(.clk(clk), .nrst(nrst), .lnk(lnk.reader),
    .cmdValid(cmdValid), .cmdReady(cmdReady), .cmdOp(cmdOp), .cmdAddr(cmdAddr), .cmdOperand(cmdOperand),
    .rspValid(rspValid), .rspCode(rspCode), .rspTimeout(rspTimeout));
  cvo_card cvo_card_i(.clk(clk), .nrst(nrst), .lnk(lnk.card), .authOk(authOk), .nvAddr(nvAddr), .nvOp(nvOp),
    .nvRdData(nvRdData), .nvPermit(permit[nvAddr]), .nvWrEn(nvWrEn), .nvWrData(nvWrData), .nvWrDone(nvWrDone),
    .valueReg(valueReg));
  cvo_link_sva cvo_link_sva_i(.clk(clk), .nrst(nrst), .lnkClk(lnk.lnkClk), .rdrFrm(lnk.rdrFrm),
    .rdrDat(lnk.rdrDat), .cardFrm(lnk.cardFrm), .cardDat(lnk.cardDat));
  assign nvRdData = mem[nvAddr];
  always #12.5 clk = ~clk;          // 40 MHz
  // ****************************************
  // Store model: write lands and done rises on the same edge
  // ****************************************
  always @(negedge clk) begin
    nvWrDone <= nvWrEn;
    if (nvWrEn) mem[nvAddr] <= nvWrData;
  end
  task automatic err(input string m);
    miscompares++;
    $display("[ERR] %0t %s", $time, m);
  endtask : err
  task automatic end_sim();
    if (miscompares == 0 && testsRun > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : end_sim
  // ****************************************
  // Driver: note the result, then send
  // ****************************************
  task automatic run_cmd(input logic [7:0] op, input logic [7:0] a, input logic auth);
    cvo_note_t n;
    logic [31:0] opnd;
    logic ok;
    opnd = $urandom();
    ok = auth && permit[a];         // Refusal keeps the volatile value
    if (ok && op == OP_INC) expV = mem[a] + opnd;
    if (ok && op == OP_DEC) expV = mem[a] - opnd;
    if (ok && op == OP_RES) expV = mem[a];
    n = '{ok ? RSP_ACK : RSP_NPRM, expV, a, (ok && op == OP_XFER) ? expV : mem[a]};
    notes.push_back(n);
    while (!cmdReady) @(negedge clk);
    {authOk, cmdOp, cmdAddr, cmdOperand, cmdValid} = {auth, op, a, opnd, 1'h1};
    @(negedge clk);
    cmdValid = 1'h0;                // Fields held until the next command
    do @(negedge clk); while (!rspValid);
  endtask : run_cmd
  // ****************************************
  // Monitor: compare each result to oldest note
  // ****************************************
  always @(negedge clk) begin
    cvo_note_t n;
    if (nrst && rspValid) begin
      testsRun += 3;
      if (notes.size() == 0) err("unexpected result");
      else begin
        n = notes.pop_front();
        if (rspCode !== n.code || rspTimeout !== 1'h0) err("reply code");
        if (valueReg !== n.val) err("volatile value");
        if (mem[n.ma] !== n.mv) err("stored block");
      end
    end
  end
  // Hang guard: about 45000 cycles expected
  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      miscompares++;
      end_sim();
    end
  end
  initial begin
    void'($urandom(32'h87f2464a));
    foreach (mem[i]) mem[i] = $urandom();
    permit[8'h33] = 1'h0;           // One block closed to value ops
    repeat (2) @(negedge clk);
    nrst = 1'h1;
    for (int i = 0; i < 7; i++) run_cmd(OPS[i], ADRS[i], AUTH[i]);
    repeat (4) @(negedge clk);
    if (notes.size() != 0) err("results missing");
    end_sim();
  end
endmodule : card_value_op_handler_tb
